// *** design/sensor_scratch_cfg.svh ***
// Offsets, field positions, reset values, command codes and timing counts
`ifndef SENSOR_SCRATCH_CFG_SVH
`define SENSOR_SCRATCH_CFG_SVH

// Function command codes
`define CMD_CONVERT    8'h44
`define CMD_LOAD       8'h4e
`define CMD_DUMP       8'hbe
`define CMD_COMMIT     8'h48
`define CMD_RELOAD     8'hb8

// Scratchpad byte offsets
`define OFS_TEMP_LO    4'h0
`define OFS_TEMP_HI    4'h1
`define OFS_UPPER      4'h2
`define OFS_LOWER      4'h3
`define OFS_CONFIG     4'h4
`define OFS_RSVD       4'h5
`define OFS_CHECK      4'h8

// Configuration byte fields
`define CFG_RES_MSB    6
`define CFG_RES_LSB    5
`define CFG_BIT7_VAL   1'b0
`define CFG_LOW_VAL    5'h1f
`define RES_RESET      2'h3

// Reset values and check polynomial (x^8+x^5+x^4+1, bit reversed)
`define TEMP_RESET     16'h0550
`define CRC_POLY_REFL  8'h8c

// Stream lengths in bits
`define LOAD_BITS      7'd24
`define DUMP_BITS      7'd72

// Timing
`define CLK_HZ         20000000
`define CONV_MAX_MS    750
`define NV_WRITE_MS    10
`define RELOAD_CYCLES  4

`endif

// *** design/sensor_scratch_pkg.sv ***
// Types shared by the scratchpad, identifier and check logic
package sensor_scratch_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RELOAD = 3'b000,
        ST_IDLE   = 3'b001,
        ST_LOAD   = 3'b010,
        ST_DUMP   = 3'b011,
        ST_CONV   = 3'b100,
        ST_COMMIT = 3'b101
    } state_t;

    // Decoded function command from the slot engine
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } cmd_t;

    // One bus slot: a written bit or a read request
    typedef struct packed {
        logic wr_valid;
        logic wr_bit;
        logic rd_req;
    } slot_t;

    // Result from the converter
    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } sample_t;

    // Nonvolatile image
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [1:0] res;
    } nv_t;

endpackage : sensor_scratch_pkg

// *** design/crc8_serial.sv ***
// Bit-serial check byte generator folded over a whole vector
`timescale 1ns/1ps
`default_nettype none
`include "sensor_scratch_cfg.svh"

module crc8_serial #(
    parameter int NBITS = 56
) (
    input  wire logic [NBITS-1:0] data,
    output logic      [7:0]       crc
);

    // LSB first, register cleared to zero, reflected feedback
    always_comb begin : fold
        logic fb;
        fb  = 1'b0;
        crc = 8'h00;
        for (int i = 0; i < NBITS; i++) begin
            fb  = crc[0] ^ data[i];
            crc = {1'b0, crc[7:1]} ^ (fb ? `CRC_POLY_REFL : 8'h00);
        end
    end

endmodule : crc8_serial
`default_nettype wire

// *** design/sensor_scratchpad_rom_crc.sv ***
// Scratchpad, nonvolatile image, identifier and check bytes of the sensor
// Functional notes
// - Identifier: family, 48-bit serial, check byte
// - Temperature bytes 0,1 are read-only
// - Bytes 2,3 limits, byte 4 configuration
// - Bytes 5 to 7 reserved, not writable
// - Byte 8 is check over bytes 0-7
// - Load takes bytes 2-4, LSB first
// - Dump shifts from byte 0 LSB upward
// - Commit copies limits and configuration to storage
// - Power-up reloads stored values into scratchpad
// - Reload: read slots give 0 busy, 1 done
// - Config bits 6:5 select resolution, default 11
// - Conversion time halves per resolution step down
// - Config bit 7 reads 0, bits 4:0 read 1
// - Check polynomial x^8 + x^5 + x^4 + 1
// - Check byte follows every scratchpad change
// - Mismatch never blocks a command sequence
// - Limits are 8-bit two's complement integers
// - Alarm when temp at/below low or at/above high
// - Temperature resets to +85 degrees encoding
`timescale 1ns/1ps
`default_nettype none
`include "sensor_scratch_cfg.svh"

module sensor_scratchpad_rom_crc
    import sensor_scratch_pkg::*;
#(
    parameter logic [7:0]  FAMILY_CODE   = 8'h5a,        // Arbitrary value
    parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001, // Arbitrary value
    parameter logic [23:0] RSVD_BYTES    = 24'hff_ff_ff,
    parameter logic [7:0]  NV_UPPER_INIT = 8'h7f,
    parameter logic [7:0]  NV_LOWER_INIT = 8'h80,
    parameter int          CNT_W         = 24,
    parameter int          CONV_CYCLES   = `CONV_MAX_MS * (`CLK_HZ / 1000),
    parameter int          NV_CYCLES     = `NV_WRITE_MS * (`CLK_HZ / 1000)
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire cmd_t        cmd,
    input  wire slot_t       slot,
    input  wire sample_t     sample,
    output logic             rd_bit,
    output logic      [63:0] rom_code,
    output logic             alarm_flag,
    output logic             conv_start,
    output logic             pullup_req
);
    // ****************************************************************
    // Constants and helpers
    // ****************************************************************
    localparam logic [CNT_W-1:0] CONV_CNT   = CNT_W'(CONV_CYCLES);
    localparam logic [CNT_W-1:0] NV_CNT     = CNT_W'(NV_CYCLES);
    localparam logic [CNT_W-1:0] RELOAD_CNT = CNT_W'(`RELOAD_CYCLES);
    // Conversion length for a resolution code, 12 bits is full length
    function automatic logic [CNT_W-1:0] conv_cycles(input logic [1:0] res);
        conv_cycles = CONV_CNT >> (2'd3 - res);
    endfunction : conv_cycles
    // Alarm test on the integer part, signed
    function automatic logic alarm_test(input logic [15:0] t,
                                        input logic [7:0]  hi,
                                        input logic [7:0]  lo);
        alarm_test = ($signed(t[11:4]) <= $signed(lo))
                  || ($signed(t[11:4]) >= $signed(hi));
    endfunction : alarm_test
    // ****************************************************************
    // State
    // ****************************************************************
    state_t           state_reg,      state_next;      // Sequencer
    logic [CNT_W-1:0] cnt_reg,        cnt_next;        // Timer
    logic [6:0]       idx_reg,        idx_next;        // Bit index
    logic [7:0]       shift_reg,      shift_next;      // Load shifter
    logic [15:0]      temp_reg,       temp_next;       // Temperature
    logic [7:0]       upper_reg,      upper_next;      // High limit
    logic [7:0]       lower_reg,      lower_next;      // Low limit
    logic [1:0]       res_reg,        res_next;        // Resolution
    nv_t              nv_reg,         nv_next;         // Stored image
    logic [15:0]      hold_reg,       hold_next;       // Pending sample
    logic             seen_reg,       seen_next;       // Sample arrived
    logic             rd_bit_reg,     rd_bit_next;     // Slot answer
    logic             alarm_reg,      alarm_next;      // Alarm flag
    logic             start_reg,      start_next;      // Convert pulse
    logic             pullup_reg,     pullup_next;     // Pullup needed
    logic [7:0]       chk_reg,        chk_next;        // Scratch check
    logic [63:0]      rom_reg,        rom_next;        // Identifier
    logic [7:0]       cfg_byte;       // Configuration as read
    logic [63:0]      scratch_vec;    // Bytes 0 to 7
    logic [71:0]      dump_vec;       // Bytes 0 to 8
    logic [7:0]       scratch_chk;    // Check of bytes 0 to 7
    logic [7:0]       rom_chk;        // Check of identifier
    logic [7:0]       load_byte;      // Byte completed by this bit
    logic [15:0]      conv_value;     // Value to store at conversion end

    // ****************************************************************
    // Scratchpad image and check bytes
    // ****************************************************************
    // Reserved configuration bits are constants, writes never reach them
    assign cfg_byte = {`CFG_BIT7_VAL, res_reg, `CFG_LOW_VAL};
    // Byte 0 at the bottom so bit index equals stream order; bytes 5-7 fixed
    assign scratch_vec = {RSVD_BYTES, cfg_byte, lower_reg, upper_reg,
                          temp_reg};
    assign dump_vec    = {chk_reg, scratch_vec};
    // Check over scratchpad bytes 0 to 7
    crc8_serial #(
        .NBITS (64)
    ) u_scratch_chk (
        .data  (scratch_vec),
        .crc   (scratch_chk)
    );
    // Check over family code and serial number
    crc8_serial #(
        .NBITS (56)
    ) u_rom_chk (
        .data  ({SERIAL_NUMBER, FAMILY_CODE}),
        .crc   (rom_chk)
    );
    // Next check and identifier values
    always_comb begin
        chk_next = scratch_chk;
        rom_next = {rom_chk, SERIAL_NUMBER, FAMILY_CODE};
    end
    // Register check and identifier
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chk_reg <= 8'h00;
            rom_reg <= 64'h0;
        end else if (ce) begin
            chk_reg <= chk_next;
            rom_reg <= rom_next;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    assign load_byte  = {slot.wr_bit, shift_reg[7:1]};
    assign conv_value = (sample.valid) ? sample.value :
                        (seen_reg)     ? hold_reg     : temp_reg;
    // Next state of commands, slots and scratchpad contents
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        idx_next    = idx_reg;
        shift_next  = shift_reg;
        temp_next   = temp_reg;
        upper_next  = upper_reg;
        lower_next  = lower_reg;
        res_next    = res_reg;
        nv_next     = nv_reg;
        hold_next   = hold_reg;
        seen_next   = seen_reg;
        rd_bit_next = rd_bit_reg;
        alarm_next  = alarm_reg;
        start_next  = 1'b0;
        pullup_next = pullup_reg;
        unique case (state_reg)
            // Copy stored image in; entered from reset and on command
            ST_RELOAD: begin
                if (slot.rd_req) begin
                    rd_bit_next = 1'b0;
                end
                if (cnt_reg == '0) begin
                    upper_next = nv_reg.upper;
                    lower_next = nv_reg.lower;
                    res_next   = nv_reg.res;
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            // Wait for a function command; idle read slots see 1
            ST_IDLE: begin
                if (slot.rd_req) begin
                    rd_bit_next = 1'b1;
                end
                if (cmd.valid) begin
                    idx_next = 7'd0;
                    if (cmd.code == `CMD_CONVERT) begin
                        state_next  = ST_CONV;
                        cnt_next    = conv_cycles(res_reg);
                        start_next  = 1'b1;
                        pullup_next = 1'b1;
                        seen_next   = 1'b0;
                    end else if (cmd.code == `CMD_LOAD) begin
                        state_next = ST_LOAD;
                    end else if (cmd.code == `CMD_DUMP) begin
                        state_next = ST_DUMP;
                    end else if (cmd.code == `CMD_COMMIT) begin
                        state_next  = ST_COMMIT;
                        cnt_next    = NV_CNT;
                        nv_next     = '{upper_reg, lower_reg, res_reg};
                        pullup_next = 1'b1;
                    end else if (cmd.code == `CMD_RELOAD) begin
                        state_next = ST_RELOAD;
                        cnt_next   = RELOAD_CNT;
                    end
                end
            end
            // Bytes 2, 3, 4 in order, LSB first; each byte lands when whole
            ST_LOAD: begin
                if (cmd.valid) begin
                    state_next = ST_IDLE;
                end else if (slot.wr_valid) begin
                    shift_next = load_byte;
                    idx_next   = idx_reg + 7'd1;
                    if (idx_reg[2:0] == 3'd7) begin
                        unique case (idx_reg[4:3])
                            2'd0:    upper_next = load_byte;
                            2'd1:    lower_next = load_byte;
                            default: res_next   =
                                load_byte[`CFG_RES_MSB:`CFG_RES_LSB];
                        endcase
                    end
                    if (idx_reg == `LOAD_BITS - 7'd1) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            // Shift bytes 0 to 8 out; no check on what the master does
            ST_DUMP: begin
                if (cmd.valid) begin
                    state_next = ST_IDLE;
                end else if (slot.rd_req) begin
                    if (idx_reg < `DUMP_BITS) begin
                        rd_bit_next = dump_vec[idx_reg];
                        idx_next    = idx_reg + 7'd1;
                    end else begin
                        rd_bit_next = 1'b1;
                    end
                end
            end
            // Conversion runs on the strong pullup; slots are not expected
            ST_CONV: begin
                if (sample.valid) begin
                    hold_next = sample.value;
                    seen_next = 1'b1;
                end
                if (cnt_reg == '0) begin
                    temp_next   = conv_value;
                    alarm_next  = alarm_test(conv_value, upper_reg,
                                             lower_reg);
                    pullup_next = 1'b0;
                    state_next  = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            // Nonvolatile write time on the strong pullup
            ST_COMMIT: begin
                if (cnt_reg == '0) begin
                    pullup_next = 1'b0;
                    state_next  = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            // Unused codes recover to idle
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Register sequencer and scratchpad; power-up starts with a reload
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg  <= ST_RELOAD;
            cnt_reg    <= RELOAD_CNT;
            idx_reg    <= 7'd0;
            shift_reg  <= 8'h00;
            temp_reg   <= `TEMP_RESET;
            upper_reg  <= 8'h00;
            lower_reg  <= 8'h00;
            res_reg    <= `RES_RESET;
            nv_reg     <= '{NV_UPPER_INIT, NV_LOWER_INIT, `RES_RESET};
            hold_reg   <= 16'h0000;
            seen_reg   <= 1'b0;
            rd_bit_reg <= 1'b1;
            alarm_reg  <= 1'b0;
            start_reg  <= 1'b0;
            pullup_reg <= 1'b0;
        end else if (ce) begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            idx_reg    <= idx_next;
            shift_reg  <= shift_next;
            temp_reg   <= temp_next;
            upper_reg  <= upper_next;
            lower_reg  <= lower_next;
            res_reg    <= res_next;
            nv_reg     <= nv_next;
            hold_reg   <= hold_next;
            seen_reg   <= seen_next;
            rd_bit_reg <= rd_bit_next;
            alarm_reg  <= alarm_next;
            start_reg  <= start_next;
            pullup_reg <= pullup_next;
        end
    end

    // Outputs straight from flip-flops
    assign rd_bit     = rd_bit_reg;
    assign rom_code   = rom_reg;
    assign alarm_flag = alarm_reg;
    assign conv_start = start_reg;
    assign pullup_req = pullup_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_conv_go;
        ce && state_reg == ST_IDLE && cmd.valid && cmd.code == `CMD_CONVERT;
    endsequence
    sequence s_commit_go;
        ce && state_reg == ST_IDLE && cmd.valid && cmd.code == `CMD_COMMIT;
    endsequence
    sequence s_reload_go;
        ce && state_reg == ST_IDLE && cmd.valid && cmd.code == `CMD_RELOAD;
    endsequence

    conv_timer_a: assert property (s_conv_go |=>
        cnt_reg == conv_cycles($past(res_reg)) && pullup_reg && start_reg)
        else $error("conversion timer or pullup wrong at start");
    conv_alarm_a: assert property (
        ce && state_reg == ST_CONV && cnt_reg == '0 |=>
        alarm_reg == alarm_test(temp_reg, upper_reg, lower_reg) && !pullup_reg)
        else $error("alarm flag does not match limits");
    temp_ro_a: assert property (
        ce && state_reg == ST_LOAD |=> $stable(temp_reg))
        else $error("load changed temperature bytes");
    cfg_write_a: assert property (
        ce && state_reg == ST_LOAD && !cmd.valid && slot.wr_valid
        && idx_reg == 7'd23 |=> res_reg == $past(shift_reg[7:6])
        && state_reg == ST_IDLE)
        else $error("resolution not taken from third byte");
    // One enabled edge after the image settles, the check byte must match it
    chk_follow_a: assert property (
        ce ##1 $stable(scratch_vec) |-> chk_reg == scratch_chk)
        else $error("scratch check byte stale");
    dump_first_a: assert property (
        ce && state_reg == ST_DUMP && !cmd.valid && slot.rd_req
        && idx_reg == 7'd0 |=> rd_bit_reg == temp_reg[0] && idx_reg == 7'd1)
        else $error("dump does not start at byte 0 bit 0");
    recall_busy_a: assert property (
        ce && state_reg == ST_RELOAD && slot.rd_req |=> !rd_bit_reg)
        else $error("read slot during reload not 0");
    recall_len_a: assert property (
        s_reload_go ##1 ce [*5] |=> state_reg == ST_IDLE)
        else $error("reload did not finish in time");
    commit_copy_a: assert property (s_commit_go |=>
        nv_reg == $past({upper_reg, lower_reg, res_reg}) && pullup_reg)
        else $error("commit did not copy scratchpad");
    reload_copy_a: assert property (
        ce && state_reg == ST_RELOAD && cnt_reg == '0 |=>
        upper_reg == nv_reg.upper && lower_reg == nv_reg.lower
        && res_reg == nv_reg.res)
        else $error("reload did not restore limits");
    rom_chk_a: assert property (
        ce |=> rom_code[63:56] == rom_chk && rom_code[7:0] == FAMILY_CODE)
        else $error("identifier check byte wrong");
endmodule : sensor_scratchpad_rom_crc
`default_nettype wire

// *** tb/line_master_model.sv ***
// Bus master model: commands, write and read slots, check byte test
`timescale 1ns/1ps
`default_nettype none
module line_master_model
    import sensor_scratch_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic pullup_req,
    input  wire logic rd_bit,
    output var cmd_t  cmd,
    output var slot_t slot,
    output logic      strong_pullup
);
    initial begin
        cmd = '0;
        slot = '0;
    end

    // Strong pullup follows the request with no delay
    assign strong_pullup = pullup_req;

    // One command pulse; waits up to 4000 cycles for the pullup to go off
    task automatic issue(input logic [7:0] code);
        for (int k = 0; k < 4000 && pullup_req; k++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        cmd <= {1'b1, code};
        @(negedge core_clk);
        cmd <= '0;
    endtask : issue

    // Write slots, least significant bit first
    task automatic put_bits(input logic [71:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            slot <= {1'b1, d[i], 1'b0};
            @(negedge core_clk);
        end
        slot <= '0;
    endtask : put_bits

    // Read slots, back to back; answer taken one cycle later
    task automatic get_bits(input int n, output logic [71:0] d);
        d = '0;
        for (int i = 0; i <= n; i++) begin
            if (i > 0) begin
                @(negedge core_clk);
                d[i-1] = rd_bit;
            end
            slot <= {2'b00, i < n};
        end
    endtask : get_bits

    // Register cleared, data and check byte shifted LSB first; zero means clean
    function automatic logic [7:0] crc_res(input logic [71:0] d, input int n);
        logic [7:0] r;
        logic       fb;
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            fb = r[0] ^ d[i];
            r = r >> 1;
            if (fb) r = r ^ 8'h8c;
        end
        return r;
    endfunction : crc_res
endmodule : line_master_model
`default_nettype wire

// *** tb/tb_sensor_scratchpad_rom_crc.sv ***
// Self-checking bench for the scratchpad, identifier and check bytes
`timescale 1ns/1ps
`default_nettype none
`include "sensor_scratch_cfg.svh"
module tb_sensor_scratchpad_rom_crc
    import sensor_scratch_pkg::*;
;
    localparam logic [7:0]  FAMILY = 8'h3c;          // Arbitrary value
    localparam logic [47:0] SERIAL = 48'h0000_1234_5678; // Arbitrary value
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic        ce       = 1'b1;
    sample_t     sample   = '0;
    cmd_t        cmd;
    slot_t       slot;
    logic        rd_bit, alarm_flag, pullup_req, conv_start;
    logic [63:0] rom_code;
    logic [71:0] d;
    int          fails = 0;
    int          total_checks = 0;

    always #25 core_clk = ~core_clk;

    sensor_scratchpad_rom_crc #(.FAMILY_CODE(FAMILY), .SERIAL_NUMBER(SERIAL),
        .RSVD_BYTES(24'hff_ff_ff), .NV_UPPER_INIT(8'h7f), .NV_LOWER_INIT(8'h80),
        .CONV_CYCLES(64), .NV_CYCLES(20)) sensor_scratchpad_rom_crc_i (
        .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .cmd(cmd), .slot(slot),
        .sample(sample), .rd_bit(rd_bit), .rom_code(rom_code),
        .alarm_flag(alarm_flag), .conv_start(conv_start), .pullup_req(pullup_req));

    line_master_model line_master_model_i (.core_clk(core_clk), .pullup_req(pullup_req),
        .rd_bit(rd_bit), .cmd(cmd), .slot(slot), .strong_pullup());

    task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Full dump compared byte for byte, then the check byte by the master
    task automatic dump_check(input logic [15:0] t, input logic [7:0] up, lo, cfg);
        line_master_model_i.issue(`CMD_DUMP);
        line_master_model_i.get_bits(72, d);
        check("pad", d[63:0], {24'hff_ff_ff, cfg, lo, up, t});
        check("pad crc", line_master_model_i.crc_res(d, 72), 0);
        // A dump stays open; any command pulse closes it and is itself dropped
        line_master_model_i.issue(8'h00);
    endtask : dump_check

    task automatic load(input logic [7:0] up, lo, cfg);
        line_master_model_i.issue(`CMD_LOAD);
        line_master_model_i.put_bits({48'h0, cfg, lo, up}, 24);
    endtask : load

    // Powered command: counts pullup and start cycles, offers one sample meanwhile
    task automatic powered(input logic [7:0] code, input logic [15:0] t, input int exp_n);
        int n;
        int s;
        n = 0;
        s = 0;
        line_master_model_i.issue(code);
        for (int k = 0; k < 3 && pullup_req !== 1'b1; k++) @(negedge core_clk);
        while (pullup_req === 1'b1 && n < 2000) begin
            sample <= {n == 0, t};
            if (conv_start !== 1'b0) s++;
            n++;
            @(negedge core_clk);
        end
        sample <= '0;
        check("pullup len", n, exp_n);
        check("start pulse", s, code == `CMD_CONVERT);
    endtask : powered

    // Clock enable low: a command pulse is missed, idle read slots stay 1
    task automatic frozen;
        ce <= 1'b0;
        line_master_model_i.issue(`CMD_DUMP);
        ce <= 1'b1;
        line_master_model_i.get_bits(8, d);
        check("frozen", d[7:0], 8'hff);
    endtask : frozen

    initial begin
        #1000000;
        fails++;
        tally_and_finish;
    end

    initial begin
        repeat (12) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (8) @(negedge core_clk);
        check("rom id", rom_code[55:0], {SERIAL, FAMILY});
        check("rom crc", line_master_model_i.crc_res(rom_code, 64), 0);
        dump_check(16'h0550, 8'h7f, 8'h80, 8'h7f);
        load(8'h19, 8'hf6, 8'h80);
        dump_check(16'h0550, 8'h19, 8'hf6, 8'h1f);
        powered(`CMD_CONVERT, 16'h0191, 9);
        check("alarm high", alarm_flag, 1);
        dump_check(16'h0191, 8'h19, 8'hf6, 8'h1f);
        powered(`CMD_COMMIT, 16'h0123, 21);
        load(8'h7f, 8'h00, 8'h7f);
        powered(`CMD_CONVERT, 16'h0180, 65);
        check("alarm clear", alarm_flag, 0);
        load(8'h7f, 8'h00, 8'h20);
        powered(`CMD_CONVERT, 16'h0180, 17);
        load(8'h7f, 8'h00, 8'h40);
        powered(`CMD_CONVERT, 16'h0180, 33);
        line_master_model_i.issue(`CMD_RELOAD);
        line_master_model_i.get_bits(8, d);
        check("reload status", d[7:0], 8'he0);
        frozen;
        dump_check(16'h0180, 8'h19, 8'hf6, 8'h1f);
        tally_and_finish;
    end
endmodule : tb_sensor_scratchpad_rom_crc
`default_nettype wire
